// file: common/psq_pkg.sv
// constants, types and behaviour list for the paired single quantizer
//
// Behaviour
// - load scale is 6-bit two's complement, -32 up to 31.
// - float type loads pass cache word unchanged, denormals included.
// - store moves operand to store queue first, then writes cache.
// - store adds store scale to exponent before mantissa shifting.
// - mantissa shifted until exponent is zero, giving integer magnitude.
// - sign and magnitude become two's complement before reduction.
// - reduction rounds toward zero, fraction bits discarded.
// - unsigned overflow saturates to 0, 255 or 65535.
// - signed overflow saturates to -128/127 or -32768/32767.
// - plus infinity or NaN with sign 0 gives positive saturation.
// - minus infinity or NaN with sign 1 gives negative saturation.
// - stored integer is operand times two to store scale, truncated, clamped.
// - float type stores pass operand to cache unchanged, except denormals.
// - float type store of a denormal writes 0.0.
// - dequantized float equals integer times two to minus load scale.
// - dequantize: sign-magnitude, normalize, subtract load scale from exponent.
// - types are signed or unsigned 8 or 16 bit against 32-bit float.
// - both operands of a pair use identical type and scale.
package psq_pkg;
  // ---------------------------------------------------------------
  // quant config register field layout
  // ---------------------------------------------------------------
  localparam int ST_TYPE_LSB = 0;
  localparam int STORE_SCALE_LSB = 8;
  localparam int LD_TYPE_LSB = 16;
  localparam int LOAD_SCALE_LSB = 24;
  localparam int TYPE_W = 3;
  localparam int SCALE_W = 6;
  // ---------------------------------------------------------------
  // quantized type codes
  // ---------------------------------------------------------------
  localparam logic [2:0] QT_FLOAT = 3'h0;
  localparam logic [2:0] QT_U8 = 3'h4;
  localparam logic [2:0] QT_U16 = 3'h5;
  localparam logic [2:0] QT_S8 = 3'h6;
  localparam logic [2:0] QT_S16 = 3'h7;
  // ---------------------------------------------------------------
  // float format and saturation values
  // ---------------------------------------------------------------
  localparam logic [7:0] FLT_BIAS = 8'h7f;
  localparam logic [7:0] FLT_EXP_MAX = 8'hff;
  localparam logic signed [17:0] U8_MAX = 18'sh000ff;
  localparam logic signed [17:0] U16_MAX = 18'sh0ffff;
  localparam logic signed [17:0] S8_MAX = 18'sh0007f;
  localparam logic signed [17:0] S8_MIN = -18'sh00080;
  localparam logic signed [17:0] S16_MAX = 18'sh07fff;
  localparam logic signed [17:0] S16_MIN = -18'sh08000;
  localparam logic signed [9:0] INT_EXP_LIMIT = 10'sh011;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_QUEUE = 2'b01,
    ST_CONV = 2'b10
  } seq_state_e;
endpackage : psq_pkg

// file: common/conv_if.sv
// per-operand conversion carrier between sequencer and lane
`timescale 1ns/10ps
interface conv_if;
  logic [31:0] operand;
  logic store;
  logic [2:0] qtype;
  logic [5:0] scale;
  logic [31:0] result;
  modport ctrl (output operand, output store, output qtype, output scale, input result);
  modport lane (input operand, input store, input qtype, input scale, output result);
endinterface : conv_if

// file: hdl/quant_lane.sv
// combinational quantize / dequantize of one operand
`timescale 1ns/10ps
module quant_lane (
  conv_if.lane io
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] lead_one(input logic [15:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (v[i])
      begin
        p = 4'(i);
      end
    end
    return p;
  endfunction : lead_one

  logic sign;
  logic [7:0] fexp;
  logic [22:0] frac;
  logic signed [9:0] sc;
  logic signed [9:0] e_scaled;
  logic [39:0] shifted;
  logic [16:0] mag;
  logic signed [17:0] sval;
  logic signed [17:0] lo;
  logic signed [17:0] hi;
  logic is_int;
  logic is_sig;
  logic is16;
  logic [31:0] qres;
  logic signed [16:0] ival;
  logic [15:0] imag;
  logic [3:0] lead;
  logic [7:0] dexp;
  logic [38:0] norm;
  logic [31:0] dres;

  // ---------------------------------------------------------------
  // conversion
  // ---------------------------------------------------------------
  always_comb
  begin
    sign = io.operand[31];
    fexp = io.operand[30:23];
    frac = io.operand[22:0];
    sc = $signed({{4{io.scale[5]}}, io.scale}); // two's complement scale
    is_int = io.qtype[2];
    is_sig = (io.qtype == psq_pkg::QT_S8) || (io.qtype == psq_pkg::QT_S16);
    is16 = (io.qtype == psq_pkg::QT_U16) || (io.qtype == psq_pkg::QT_S16);
    // scale added to exponent before any shift
    e_scaled = $signed({2'b00, fexp}) - $signed({2'b00, psq_pkg::FLT_BIAS}) + sc;
    shifted = 40'h0;
    // shift until exponent is zero, fraction dropped toward zero
    if ((e_scaled >= 10'sh000) && (e_scaled < psq_pkg::INT_EXP_LIMIT) && (fexp != 8'h00))
    begin
      shifted = {16'h0000, 1'b1, frac} << e_scaled[4:0];
    end
    mag = shifted[39:23];
    sval = sign ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    lo = is_sig ? (is16 ? psq_pkg::S16_MIN : psq_pkg::S8_MIN) : 18'sh00000;
    hi = is_sig ? (is16 ? psq_pkg::S16_MAX : psq_pkg::S8_MAX)
                : (is16 ? psq_pkg::U16_MAX : psq_pkg::U8_MAX);
    if (!is_int)
    begin
      // float store passes, denormal becomes 0.0
      qres = ((fexp == 8'h00) && (frac != 23'h0)) ? 32'h00000000 : io.operand;
    end
    else if ((fexp == psq_pkg::FLT_EXP_MAX) || (e_scaled >= psq_pkg::INT_EXP_LIMIT))
    begin
      // infinities, NaNs and large values saturate by sign
      qres = {14'h0000, sign ? lo : hi};
    end
    else if (sval > hi)
    begin
      qres = {14'h0000, hi};
    end
    else if (sval < lo)
    begin
      qres = {14'h0000, lo};
    end
    else
    begin
      qres = {14'h0000, sval};
    end
    // dequantize: sign and magnitude by type
    if (is16)
    begin
      ival = is_sig ? $signed({io.operand[15], io.operand[15:0]}) : $signed({1'b0, io.operand[15:0]});
    end
    else
    begin
      ival = is_sig ? $signed({{9{io.operand[7]}}, io.operand[7:0]})
                    : $signed({9'h000, io.operand[7:0]});
    end
    imag = ival[16] ? 16'(-ival) : ival[15:0];
    lead = lead_one(imag);
    // exponent minus load scale gives I * 2^-S
    dexp = 8'($signed({2'b00, psq_pkg::FLT_BIAS}) + $signed({6'h00, lead}) - sc);
    norm = {23'h000000, imag} << (5'd23 - {1'b0, lead});
    dres = (imag == 16'h0000) ? 32'h00000000 : {ival[16], dexp, norm[22:0]};
    if (io.store)
    begin
      io.result = qres;
    end
    else
    begin
      io.result = is_int ? dres : io.operand; // float load unchanged
    end
  end
endmodule : quant_lane

// file: hdl/paired_single_quantizer.sv
// paired single quantizer: handshake, sequencing and pair packing
`timescale 1ns/10ps
module paired_single_quantizer (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire logic req_store_i,
  input wire logic [31:0] quant_config_register_i,
  input wire logic [63:0] float_register_entry_i,
  input wire logic [63:0] ld_data_i,
  output logic req_ready_o,
  output logic freg_wr_valid_o,
  output logic [63:0] freg_wr_data_o,
  output logic stq_valid_o,
  output logic [63:0] stq_data_o,
  output logic dc_wr_valid_o,
  output logic [63:0] dc_wr_data_o
);
  typedef struct packed {
    psq_pkg::seq_state_e state;
    logic store;
    logic [2:0] qtype;
    logic [5:0] scale;
    logic [63:0] op;
    logic ready;
    logic freg_valid;
    logic [63:0] freg_data;
    logic stq_valid;
    logic [63:0] stq_data;
    logic dc_valid;
    logic [63:0] dc_data;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [1:0] rst_sync_r;
  logic rstn;
  conv_if lane_hi ();
  conv_if lane_lo ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // big-endian unpack of a cache pair into two operands
  function automatic logic [63:0] unpack(input logic [63:0] d, input logic [2:0] t);
    logic [63:0] r;
    r = d;
    if ((t == psq_pkg::QT_U16) || (t == psq_pkg::QT_S16))
    begin
      r = {16'h0000, d[63:48], 16'h0000, d[47:32]};
    end
    else if (t[2])
    begin
      r = {24'h000000, d[63:56], 24'h000000, d[55:48]};
    end
    return r;
  endfunction : unpack

  // big-endian pack of two converted values toward the cache
  function automatic logic [63:0] pack(input logic [31:0] a, input logic [31:0] b,
                                       input logic [2:0] t);
    logic [63:0] r;
    r = {a, b};
    if ((t == psq_pkg::QT_U16) || (t == psq_pkg::QT_S16))
    begin
      r = {a[15:0], b[15:0], 32'h00000000};
    end
    else if (t[2])
    begin
      r = {a[7:0], b[7:0], 48'h000000000000};
    end
    return r;
  endfunction : pack

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_sync_r <= 2'b00;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rstn = rst_sync_r[1];

  // ---------------------------------------------------------------
  // lanes: both share type and scale
  // ---------------------------------------------------------------
  assign lane_hi.operand = st_r.op[63:32];
  assign lane_lo.operand = st_r.op[31:0];
  assign lane_hi.store = st_r.store;
  assign lane_lo.store = st_r.store;
  assign lane_hi.qtype = st_r.qtype;
  assign lane_lo.qtype = st_r.qtype;
  assign lane_hi.scale = st_r.scale;
  assign lane_lo.scale = st_r.scale;

  quant_lane u_lane_hi (
    .io(lane_hi)
  );

  quant_lane u_lane_lo (
    .io(lane_lo)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.freg_valid = 1'b0;
    st_nxt.stq_valid = 1'b0;
    st_nxt.dc_valid = 1'b0;
    unique case (st_r.state)
      psq_pkg::ST_IDLE:
      begin
        if (req_valid_i)
        begin
          // take one pair, stall until its result is out
          st_nxt.ready = 1'b0;
          st_nxt.store = req_store_i;
          if (req_store_i)
          begin
            st_nxt.qtype = quant_config_register_i[psq_pkg::ST_TYPE_LSB +: psq_pkg::TYPE_W];
            st_nxt.scale = quant_config_register_i[psq_pkg::STORE_SCALE_LSB +: psq_pkg::SCALE_W];
            st_nxt.op = float_register_entry_i;
            // operand goes to the store queue first
            st_nxt.stq_valid = 1'b1;
            st_nxt.stq_data = float_register_entry_i;
            st_nxt.state = psq_pkg::ST_QUEUE;
          end
          else
          begin
            st_nxt.qtype = quant_config_register_i[psq_pkg::LD_TYPE_LSB +: psq_pkg::TYPE_W];
            st_nxt.scale = quant_config_register_i[psq_pkg::LOAD_SCALE_LSB +: psq_pkg::SCALE_W];
            st_nxt.op = unpack(ld_data_i,
                               quant_config_register_i[psq_pkg::LD_TYPE_LSB +: psq_pkg::TYPE_W]);
            st_nxt.state = psq_pkg::ST_CONV;
          end
        end
      end
      psq_pkg::ST_QUEUE:
      begin
        st_nxt.state = psq_pkg::ST_CONV;
      end
      psq_pkg::ST_CONV:
      begin
        if (st_r.store)
        begin
          // converted pair to the cache after the queue push
          st_nxt.dc_valid = 1'b1;
          st_nxt.dc_data = pack(lane_hi.result, lane_lo.result, st_r.qtype);
        end
        else
        begin
          st_nxt.freg_valid = 1'b1;
          st_nxt.freg_data = {lane_hi.result, lane_lo.result};
        end
        st_nxt.ready = 1'b1;
        st_nxt.state = psq_pkg::ST_IDLE;
      end
      default:
      begin
        st_nxt.state = psq_pkg::ST_IDLE;
        st_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '{state: psq_pkg::ST_IDLE, ready: 1'b1, default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign req_ready_o = st_r.ready;
  assign freg_wr_valid_o = st_r.freg_valid;
  assign freg_wr_data_o = st_r.freg_data;
  assign stq_valid_o = st_r.stq_valid;
  assign stq_data_o = st_r.stq_data;
  assign dc_wr_valid_o = st_r.dc_valid;
  assign dc_wr_data_o = st_r.dc_data;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn);

  AST_QUEUE_BEFORE_CACHE: assert property (dc_wr_valid_o |-> $past(stq_valid_o, 2))
    else $error("cache write without earlier store queue push");
  AST_STALL_BUSY: assert property ((req_valid_i && req_ready_o) |=> !req_ready_o)
    else $error("ready not dropped while busy");
  AST_LOAD_LATENCY: assert property (
    (req_valid_i && req_ready_o && !req_store_i) |-> ##2 (freg_wr_valid_o && req_ready_o))
    else $error("load result not returned in two cycles");
  // store: queue push, one idle cycle, then the cache write with ready back
  AST_STORE_LATENCY: assert property (
    (req_valid_i && req_ready_o && req_store_i) |=> (stq_valid_o && !req_ready_o)
    ##1 !req_ready_o ##1 (dc_wr_valid_o && req_ready_o))
    else $error("store push or cache write off its cycle");
  AST_FLOAT_LOAD_PASS: assert property (
    (freg_wr_valid_o && $past(st_r.qtype) == psq_pkg::QT_FLOAT)
    |-> freg_wr_data_o == $past(st_r.op))
    else $error("float load altered");
  AST_FLOAT_STORE_PASS: assert property (
    (dc_wr_valid_o && $past(st_r.qtype) == psq_pkg::QT_FLOAT && $past(st_r.op[62:55]) != 8'h00)
    |-> dc_wr_data_o[63:32] == $past(st_r.op[63:32]))
    else $error("float store altered");
  AST_DENORM_ZERO: assert property (
    (dc_wr_valid_o && $past(st_r.qtype) == psq_pkg::QT_FLOAT
     && $past(st_r.op[62:55]) == 8'h00 && $past(st_r.op[54:32]) != 23'h0)
    |-> dc_wr_data_o[63:32] == 32'h00000000)
    else $error("denormal store not zeroed");
  AST_POS_INF_SAT: assert property (
    (dc_wr_valid_o && $past(st_r.qtype) == psq_pkg::QT_S16
     && $past(st_r.op[63:32]) == 32'h7f800000)
    |-> dc_wr_data_o[63:48] == 16'h7fff)
    else $error("plus infinity not saturated");
  AST_NEG_INF_SAT: assert property (
    (dc_wr_valid_o && $past(st_r.qtype) == psq_pkg::QT_S8
     && $past(st_r.op[63:32]) == 32'hff800000)
    |-> dc_wr_data_o[63:56] == 8'h80)
    else $error("minus infinity not saturated");
  AST_U8_ONE: assert property (
    (dc_wr_valid_o && $past(st_r.qtype) == psq_pkg::QT_U8
     && $past(st_r.scale) == 6'h00 && $past(st_r.op[63:32]) == 32'h3f800000)
    |-> dc_wr_data_o[63:56] == 8'h01)
    else $error("1.0 to u8 not 1");
endmodule : paired_single_quantizer

// file: test/cache_model.sv
// data cache and store queue model facing the quantizer's far side
`timescale 1ns/10ps
module cache_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire logic [63:0] fill_i,
  input wire logic stq_valid_i,
  input wire logic dc_wr_valid_i,
  input wire logic [63:0] dc_wr_data_i,
  output logic [63:0] ld_data_o,
  output logic [63:0] last_wr_o,
  output logic [7:0] wr_count_o,
  output logic order_err_o
);
  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  // read data is only valid with a request; otherwise the inverse shows
  assign ld_data_o = req_valid_i ? fill_i : ~fill_i;

  // ---------------------------------------------------------------
  // write side
  // ---------------------------------------------------------------
  logic pending_r;

  // a cache write must follow its store queue push
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pending_r <= 1'b0;
      order_err_o <= 1'b0;
      last_wr_o <= 64'h0;
      wr_count_o <= 8'h0;
    end
    else
    begin
      if (stq_valid_i)
        pending_r <= 1'b1;
      if (dc_wr_valid_i)
      begin
        if (!pending_r)
          order_err_o <= 1'b1;
        pending_r <= stq_valid_i;
        last_wr_o <= dc_wr_data_i;
        wr_count_o <= wr_count_o + 8'h1;
      end
    end
  end
endmodule : cache_model

// file: test/testbench.sv
// self-checking bench for the paired single quantizer
`timescale 1ns/10ps
module testbench;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_store_i = 1'b0;
  logic [31:0] quant_config_register_i = 32'h0;
  logic [63:0] float_register_entry_i = 64'h0;
  logic [63:0] fill = 64'h0;
  logic [63:0] ld_data_i;
  logic req_ready_o;
  logic freg_wr_valid_o;
  logic [63:0] freg_wr_data_o;
  logic stq_valid_o;
  logic [63:0] stq_data_o;
  logic dc_wr_valid_o;
  logic [63:0] dc_wr_data_o;
  logic [63:0] last_wr;
  logic [7:0] wr_count;
  logic order_err;
  int n_errors = 0;
  int tests_run = 0;
  int n_stores = 0;

  paired_single_quantizer paired_single_quantizer_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_store_i(req_store_i), .quant_config_register_i(quant_config_register_i),
    .float_register_entry_i(float_register_entry_i), .ld_data_i(ld_data_i),
    .req_ready_o(req_ready_o), .freg_wr_valid_o(freg_wr_valid_o),
    .freg_wr_data_o(freg_wr_data_o), .stq_valid_o(stq_valid_o), .stq_data_o(stq_data_o),
    .dc_wr_valid_o(dc_wr_valid_o), .dc_wr_data_o(dc_wr_data_o)
  );

  cache_model cache_model_inst (
    .clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .fill_i(fill),
    .stq_valid_i(stq_valid_o), .dc_wr_valid_i(dc_wr_valid_o), .dc_wr_data_i(dc_wr_data_o),
    .ld_data_o(ld_data_i), .last_wr_o(last_wr), .wr_count_o(wr_count),
    .order_err_o(order_err)
  );

  // 250 MHz core clock
  initial
  begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask : check

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick

  // config word: st type, store_scale_field, ld type, load_scale_field
  function automatic logic [31:0] mk(input logic [2:0] stt, input logic [5:0] sts,
                                     input logic [2:0] ldt, input logic [5:0] lds);
    return {2'h0, lds, 5'h0, ldt, 2'h0, sts, 5'h0, stt};
  endfunction : mk

  // present one request and hold it until the taking edge
  task automatic issue(input logic st, input logic [31:0] cfg, input logic [63:0] opnd,
                       input logic [63:0] ld);
    int n;
    n = 0;
    req_valid_i = 1'b1;
    req_store_i = st;
    quant_config_register_i = cfg;
    float_register_entry_i = opnd;
    fill = ld;
    while (req_ready_o !== 1'b1 && n < 20)
    begin
      tick();
      n++;
    end
    check("ready before take", {63'h0, req_ready_o}, 64'h1);
    tick();
    req_valid_i = 1'b0;
    quant_config_register_i = ~cfg;
    float_register_entry_i = ~opnd;
  endtask : issue

  task automatic do_load(input logic [2:0] ldt, input logic [5:0] lds,
                         input logic [63:0] data, input logic [63:0] exp);
    issue(1'b0, mk(3'h0, 6'h0, ldt, lds), 64'h0, data);
    check("load busy", {62'h0, req_ready_o, freg_wr_valid_o}, 64'h0);
    tick();
    check("load done", {62'h0, req_ready_o, freg_wr_valid_o}, 64'h3);
    check("load data", freg_wr_data_o, exp);
  endtask : do_load

  task automatic do_store(input logic [2:0] stt, input logic [5:0] sts,
                          input logic [63:0] opnd, input logic [63:0] exp);
    issue(1'b1, mk(stt, sts, 3'h0, 6'h0), opnd, 64'h0);
    n_stores++;
    check("queue push", {61'h0, dc_wr_valid_o, stq_valid_o, req_ready_o}, 64'h2);
    check("queue data", stq_data_o, opnd);
    tick();
    check("store gap", {61'h0, dc_wr_valid_o, stq_valid_o, req_ready_o}, 64'h0);
    tick();
    check("cache write", {61'h0, dc_wr_valid_o, stq_valid_o, req_ready_o}, 64'h5);
    check("cache data", dc_wr_data_o, exp);
  endtask : do_store

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    repeat (12) @(posedge core_clk_i);
    #1;
    check("reset ready", {63'h0, req_ready_o}, 64'h1);
    check("reset valid", {61'h0, freg_wr_valid_o, stq_valid_o, dc_wr_valid_o}, 64'h0);
    resetn_i = 1'b1;
    repeat (3) tick();
  endtask : test_reset

  task automatic test_float_load();
    do_load(psq_pkg::QT_FLOAT, 6'h05, 64'h40490fdb_00000003, 64'h40490fdb_00000003);
  endtask : test_float_load

  task automatic test_dequant();
    do_load(psq_pkg::QT_U8, 6'h3f, {16'h01ff, 48'h0}, 64'h40000000_43ff0000);
    do_load(psq_pkg::QT_S8, 6'h01, {16'hff80, 48'h0}, 64'hbf000000_c2800000);
    do_load(psq_pkg::QT_U16, 6'h1f, {32'h00010000, 32'h0}, 64'h30000000_00000000);
    do_load(psq_pkg::QT_S16, 6'h20, {32'h00018000, 32'h0}, 64'h4f800000_d7000000);
    do_load(psq_pkg::QT_U16, 6'h00, {32'hffff8000, 32'h0}, 64'h477fff00_47000000);
  endtask : test_dequant

  // 100.0 and -100.0 with overflowing scales, except u16 with scale 2 where 400 fits
  task automatic test_quant_sat();
    do_store(psq_pkg::QT_U8, 6'h02, 64'h42c80000_c2c80000, {16'hff00, 48'h0});
    do_store(psq_pkg::QT_S8, 6'h01, 64'h42c80000_c2c80000, {16'h7f80, 48'h0});
    do_store(psq_pkg::QT_U16, 6'h02, 64'h42c80000_c2c80000, {32'h01900000, 32'h0});
    do_store(psq_pkg::QT_U16, 6'h1f, 64'h42c80000_c2c80000, {32'hffff0000, 32'h0});
    do_store(psq_pkg::QT_S16, 6'h1e, 64'h42c80000_c2c80000, {32'h7fff8000, 32'h0});
  endtask : test_quant_sat

  task automatic test_quant_trunc();
    do_store(psq_pkg::QT_S16, 6'h3e, 64'h42c80000_c2c80000, {32'h0019ffe7, 32'h0});
    do_store(psq_pkg::QT_S8, 6'h00, 64'h40300000_c0300000, {16'h02fe, 48'h0});
    do_store(psq_pkg::QT_U8, 6'h20, 64'h42c80000_42c80000, 64'h0);
    do_store(psq_pkg::QT_U8, 6'h00, 64'h3f800000_3f7fffff, {16'h0100, 48'h0});
  endtask : test_quant_trunc

  task automatic test_special();
    do_store(psq_pkg::QT_S16, 6'h00, 64'h7f800000_ff800000, {32'h7fff8000, 32'h0});
    do_store(psq_pkg::QT_U8, 6'h00, 64'h7fc00000_ffc00000, {16'hff00, 48'h0});
    do_store(psq_pkg::QT_S8, 6'h03, 64'h7fffffff_ff800000, {16'h7f80, 48'h0});
    do_store(psq_pkg::QT_S8, 6'h00, 64'hff800000_7f800000, {16'h807f, 48'h0});
  endtask : test_special

  task automatic test_float_store();
    do_store(psq_pkg::QT_FLOAT, 6'h00, 64'h807fffff_00000000, 64'h0);
    do_store(psq_pkg::QT_FLOAT, 6'h07, 64'h3f800000_00000001, 64'h3f800000_00000000);
    do_store(psq_pkg::QT_FLOAT, 6'h00, 64'hff800001_c2c80000, 64'hff800001_c2c80000);
  endtask : test_float_store

  // ---------------------------------------------------------------
  // verdict and main sequence
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the fewer than a hundred cycles of traffic
  initial
  begin
    #40000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    test_reset();
    test_float_load();
    test_dequant();
    test_quant_sat();
    test_quant_trunc();
    test_special();
    test_float_store();
    tick();
    check("cache write count", {56'h0, wr_count}, 64'(n_stores));
    check("write order", {63'h0, order_err}, 64'h0);
    check("last cache word", last_wr, 64'hff800001_c2c80000);
    report_and_stop();
  end
endmodule : testbench
